// *** dcf_pkg.sv ***
package dcf_pkg;
  localparam int DATA_W    = 18;
  localparam int DEPTH_DEF = 512;
  localparam int CTRL_W    = 12;

  // synchronised pin vector layout
  localparam int PIN_WCLK  = 0;
  localparam int PIN_RCLK  = 1;
  localparam int PIN_WEN   = 2;
  localparam int PIN_REN   = 3;
  localparam int PIN_PSEL  = 4;
  localparam int PIN_WR_ENABLE_SECOND  = 5;
  localparam int PIN_RD_ENABLE_SECOND  = 6;
  localparam int PIN_OE    = 7;
  localparam int PIN_STRAP = 8;
  localparam int PIN_DATA  = 9;
  localparam int PIN_W     = PIN_DATA + DATA_W;

  // wishbone register byte addresses
  localparam logic [7:0] ADR_AE_OFF = 8'h00;
  localparam logic [7:0] ADR_AF_OFF = 8'h04;
  localparam logic [7:0] ADR_CTRL   = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;
  localparam logic [7:0] ADR_COUNT  = 8'h10;

  // control word fields
  localparam int CTRL_REINIT_BIT = 0;
  localparam int CTRL_OE_RD_BIT  = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST_STD = 12'h000;
  localparam logic [CTRL_W-1:0] CTRL_RST_ENH = 12'h03F;

  // status fields
  localparam int STAT_ENH_BIT = 5;
  localparam int STAT_RUN_BIT = 6;
  // flags {full, almost full, half, almost empty, empty}, active low
  localparam logic [4:0] FLAGS_RST = 5'h1C;

  typedef enum logic [2:0] {
    PS_AE   = 3'h1,
    PS_AF   = 3'h2,
    PS_CTRL = 3'h4
  } dcf_pstep_e;

  typedef enum logic [3:0] {
    INIT_HOLD   = 4'h1,
    INIT_SETTLE = 4'h2,
    INIT_LATCH  = 4'h4,
    INIT_RUN    = 4'h8
  } dcf_init_e;

  function automatic dcf_pstep_e next_step(input dcf_pstep_e cur, input logic enh);
    case (cur)
      PS_AE:   next_step = PS_AF;
      PS_AF:   next_step = enh ? PS_CTRL : PS_AE;
      default: next_step = PS_AE;
    endcase
  endfunction : next_step

  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    wb_merge = r;
  endfunction : wb_merge
endpackage : dcf_pkg

// *** dcf_sync_if.sv ***
`timescale 1ns/1ps
interface dcf_sync_if #(parameter int W = 1);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  modport src (output lvl, output rise);
  modport dst (input lvl, input rise);
endinterface : dcf_sync_if

// *** dcf_pin_sync.sv ***
`timescale 1ns/1ps
module dcf_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK,
  input  wire logic         RESETN,
  input  wire logic [W-1:0] raw,
  dcf_sync_if.src           sp
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // first stage feeds only the second stage
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= raw;
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) prev_reg <= '0;
    else prev_reg <= sync_reg;
  end

  assign sp.lvl  = sync_reg;
  assign sp.rise = sync_reg & ~prev_reg;
endmodule : dcf_pin_sync

// *** dcf_port_control.sv ***
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Function
// [RULE1] Active-low reset puts the device in reset state regardless of port clocks.
// [RULE2] Controlling logic resets the device after power-up before first write.
// [RULE3] Reset sets read and write pointers to the first memory location.
// [RULE4] Reset shows empty: full, almost-full, half flags high; almost-empty, empty low.
// [RULE5] Reset loads both offsets with depth/8 minus one.
// [RULE6] Strap high during reset sets control bits for standard mode.
// [RULE7] After reset, before any write, data outputs read all zero; here a register read before any write loads the register value.
// [RULE8] Strap low during reset leaves control bits 00-05 high, reprogrammable afterwards.
// [RULE9] Strap low turns expansion pins into second write and read enables.
// [RULE10] System ties the strap steadily; toggling it during operation is discouraged.
// [RULE11] Write clock edge starts array write or register write per program select.
// [RULE12] Works with aperiodic, shared or unrelated write and read clocks.
// [RULE13] Enabled, not full: one word per write edge into sequential locations.
// [RULE14] Write enable high: input register holds, nothing written to memory.
// [RULE15] Full flag low blocks writes; writing resumes once flag returns high.
// [RULE16] Enhanced mode: writing needs both write enable and second write enable.
// [RULE17] Read clock edge starts array read or register read per program select.
// [RULE18] Enabled, not empty: next word per read edge; otherwise output holds.
// [RULE19] Empty flag low blocks reads; reading resumes once flag returns high.
// [RULE20] Enhanced mode: second read enable combines with primary read enable; register reads here use the primary read enable alone.
// [RULE21] Output enable drives or floats data outputs; standard mode reads still advance.
// [RULE22] Enhanced with control bit 05: disabled outputs inhibit read pointer advance.
// [RULE23] Register writes cycle almost-empty, almost-full, then control only when enhanced.
// [RULE24] Register reads cycle almost-empty, almost-full, then control only when enhanced.
// [RULE25] Pointer state crosses between port clock domains through synchronisers; here pins are synchronised into CLK and both pointers live there.
module dcf_port_control #(
  parameter int DEPTH = dcf_pkg::DEPTH_DEF
) (
  input  wire logic                      CLK,
  input  wire logic                      RESETN,
  input  wire logic                      WCLK,
  input  wire logic                      RCLK,
  input  wire logic                      WR_ENABLE_N,
  input  wire logic                      RD_ENABLE_N,
  input  wire logic                      PROGRAM_SELECT_N,
  input  wire logic                      WR_EXPAND_OR_ENABLE2,
  input  wire logic                      RD_EXPAND_OR_ENABLE2,
  input  wire logic                      OUT_ENABLE_N,
  input  wire logic                      ENHANCED_STRAP_N,
  input  wire logic [dcf_pkg::DATA_W-1:0] DATA_IN_BUS,
  output logic      [dcf_pkg::DATA_W-1:0] DATA_OUT_BUS,
  output logic                           DATA_OUT_BUS_OE,
  output logic                           FULL_FLAG_N,
  output logic                           ALMOST_FULL_FLAG_N,
  output logic                           HALF_FULL_FLAG_N,
  output logic                           ALMOST_EMPTY_FLAG_N,
  output logic                           EMPTY_FLAG_N,
  input  wire logic                      WB_CYC_I,
  input  wire logic                      WB_STB_I,
  input  wire logic                      WB_WE_I,
  input  wire logic [7:0]                WB_ADR_I,
  input  wire logic [3:0]                WB_SEL_I,
  input  wire logic [31:0]               WB_DAT_I,
  output logic      [31:0]               WB_DAT_O,
  output logic                           WB_ACK_O
);
  localparam int AW      = $clog2(DEPTH);
  localparam int CW      = AW + 1;
  localparam int OFF_DEF = DEPTH / 8 - 1;
  localparam logic [AW-1:0] OFF_RST  = AW'(OFF_DEF);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_HALF = CW'(DEPTH / 2);

  dcf_sync_if #(.W(dcf_pkg::PIN_W)) pins ();

  logic [dcf_pkg::PIN_W-1:0]  pin_raw;
  logic [dcf_pkg::DATA_W-1:0] mem [DEPTH];
  logic [dcf_pkg::DATA_W-1:0] din;
  logic [dcf_pkg::DATA_W-1:0] in_reg;
  logic [dcf_pkg::DATA_W-1:0] dout_reg;
  logic [dcf_pkg::DATA_W-1:0] prog_rd_val;
  logic [CW-1:0]              wr_ptr_reg;
  logic [CW-1:0]              rd_ptr_reg;
  logic [CW-1:0]              cnt;
  logic [AW-1:0]              ae_off_reg;
  logic [AW-1:0]              af_off_reg;
  logic [dcf_pkg::CTRL_W-1:0] ctrl_reg;
  logic [4:0]                 flags_reg;
  logic [4:0]                 flags_next;
  logic [31:0]                bus_rdata;
  logic                       enh_reg;
  logic                       wrote_any_reg;
  logic                       ack_reg;
  dcf_pkg::dcf_init_e         init_reg;
  dcf_pkg::dcf_pstep_e        wstep_reg;
  dcf_pkg::dcf_pstep_e        rstep_reg;

  logic run, w_rise, r_rise, psel_n, wen_n, ren_n, wr_enable_second, rd_enable_second, oe_n;
  logic wen_ok, ren_ok, full_now, empty_now;
  logic wr_fire, rd_fire, wp_fire, rp_fire, psel_release, bus_wr;

  // every pin, clocks included, is sampled on CLK; both port sides then live in one domain
  assign pin_raw = {DATA_IN_BUS, ENHANCED_STRAP_N, OUT_ENABLE_N, RD_EXPAND_OR_ENABLE2,
                    WR_EXPAND_OR_ENABLE2, PROGRAM_SELECT_N, RD_ENABLE_N, WR_ENABLE_N, RCLK, WCLK};

  dcf_pin_sync #(.W(dcf_pkg::PIN_W)) u_sync (  // [RULE25]
    .CLK    (CLK),
    .RESETN (RESETN),
    .raw    (pin_raw),
    .sp     (pins.src)
  );

  // edges found by sampling, so any clock whose high and low phases each outlast a CLK period works [RULE12]
  assign w_rise = pins.rise[dcf_pkg::PIN_WCLK];
  assign r_rise = pins.rise[dcf_pkg::PIN_RCLK];
  assign psel_n = pins.lvl[dcf_pkg::PIN_PSEL];
  assign wen_n  = pins.lvl[dcf_pkg::PIN_WEN];
  assign ren_n  = pins.lvl[dcf_pkg::PIN_REN];
  assign wr_enable_second   = pins.lvl[dcf_pkg::PIN_WR_ENABLE_SECOND];
  assign rd_enable_second   = pins.lvl[dcf_pkg::PIN_RD_ENABLE_SECOND];
  assign oe_n   = pins.lvl[dcf_pkg::PIN_OE];
  assign din    = pins.lvl[dcf_pkg::PIN_DATA +: dcf_pkg::DATA_W];
  assign run    = (init_reg == dcf_pkg::INIT_RUN);

  // expansion pins act as enables only when enhanced [RULE9]
  assign wen_ok = !wen_n && (!enh_reg || wr_enable_second);  // [RULE16]
  assign ren_ok = !ren_n && (!enh_reg || rd_enable_second)  // [RULE20]
                  && !(enh_reg && ctrl_reg[dcf_pkg::CTRL_OE_RD_BIT] && oe_n);  // [RULE22]

  assign cnt       = wr_ptr_reg - rd_ptr_reg;
  assign full_now  = (cnt == CNT_FULL);
  assign empty_now = (cnt == '0);

  // flag low blocks even if the count already moved; avoids overrun on the lagging flag
  assign wr_fire = run && w_rise && psel_n && wen_ok && flags_reg[4] && !full_now;  // [RULE11] [RULE15]
  assign rd_fire = run && r_rise && psel_n && ren_ok && flags_reg[0] && !empty_now;  // [RULE17] [RULE19]
  assign wp_fire = run && w_rise && !psel_n && wen_ok;  // [RULE11]
  assign rp_fire = run && r_rise && !psel_n && !ren_n;  // [RULE17]
  assign psel_release = run && pins.rise[dcf_pkg::PIN_PSEL] && ctrl_reg[dcf_pkg::CTRL_REINIT_BIT];

  // reset is taken asynchronously by the CLK flops, independent of both port clocks [RULE1]
  // strap is only trusted once its synchroniser has refilled after release
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      init_reg <= dcf_pkg::INIT_HOLD;
    end else begin
      case (init_reg)
        dcf_pkg::INIT_HOLD:   init_reg <= dcf_pkg::INIT_SETTLE;
        dcf_pkg::INIT_SETTLE: init_reg <= dcf_pkg::INIT_LATCH;
        dcf_pkg::INIT_LATCH:  init_reg <= dcf_pkg::INIT_RUN;
        dcf_pkg::INIT_RUN:    init_reg <= dcf_pkg::INIT_RUN;
        default:              init_reg <= dcf_pkg::INIT_HOLD;
      endcase
    end
  end

  // mode latched in INIT_LATCH after release, then held; a later strap change has no effect
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) enh_reg <= 1'b0;
    else if (init_reg == dcf_pkg::INIT_LATCH) enh_reg <= !pins.lvl[dcf_pkg::PIN_STRAP];  // [RULE9]
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg <= dcf_pkg::CTRL_RST_STD;
    end else if (init_reg == dcf_pkg::INIT_LATCH) begin
      ctrl_reg <= pins.lvl[dcf_pkg::PIN_STRAP] ? dcf_pkg::CTRL_RST_STD : dcf_pkg::CTRL_RST_ENH;  // [RULE6] [RULE8]
    end else if (wp_fire && enh_reg && wstep_reg == dcf_pkg::PS_CTRL) begin
      ctrl_reg <= din[dcf_pkg::CTRL_W-1:0];  // [RULE23]
    end else if (bus_wr && WB_ADR_I == dcf_pkg::ADR_CTRL) begin
      ctrl_reg <= dcf_pkg::CTRL_W'(dcf_pkg::wb_merge(32'(ctrl_reg), WB_DAT_I, WB_SEL_I));
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ae_off_reg <= OFF_RST;  // [RULE5]
      af_off_reg <= OFF_RST;  // [RULE5]
    end else if (wp_fire && wstep_reg == dcf_pkg::PS_AE) begin
      ae_off_reg <= din[AW-1:0];  // [RULE23]
    end else if (wp_fire && wstep_reg == dcf_pkg::PS_AF) begin
      af_off_reg <= din[AW-1:0];  // [RULE23]
    end else if (bus_wr && WB_ADR_I == dcf_pkg::ADR_AE_OFF) begin
      ae_off_reg <= AW'(dcf_pkg::wb_merge(32'(ae_off_reg), WB_DAT_I, WB_SEL_I));
    end else if (bus_wr && WB_ADR_I == dcf_pkg::ADR_AF_OFF) begin
      af_off_reg <= AW'(dcf_pkg::wb_merge(32'(af_off_reg), WB_DAT_I, WB_SEL_I));
    end
  end

  // register-access sequencers; pointer parks while its enable is off
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) wstep_reg <= dcf_pkg::PS_AE;
    else if (psel_release) wstep_reg <= dcf_pkg::PS_AE;
    else if (wp_fire) wstep_reg <= dcf_pkg::next_step(wstep_reg, enh_reg);  // [RULE23]
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) rstep_reg <= dcf_pkg::PS_AE;
    else if (psel_release) rstep_reg <= dcf_pkg::PS_AE;
    else if (rp_fire) rstep_reg <= dcf_pkg::next_step(rstep_reg, enh_reg);  // [RULE24]
  end

  always_comb begin
    case (rstep_reg)
      dcf_pkg::PS_AE:   prog_rd_val = dcf_pkg::DATA_W'(ae_off_reg);
      dcf_pkg::PS_AF:   prog_rd_val = dcf_pkg::DATA_W'(af_off_reg);
      dcf_pkg::PS_CTRL: prog_rd_val = dcf_pkg::DATA_W'(ctrl_reg);
      default:          prog_rd_val = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_ptr_reg <= '0;  // [RULE3]
      rd_ptr_reg <= '0;  // [RULE3]
    end else begin
      if (wr_fire) wr_ptr_reg <= wr_ptr_reg + CW'(1);  // [RULE13]
      if (rd_fire) rd_ptr_reg <= rd_ptr_reg + CW'(1);  // [RULE18]
    end
  end

  // memory carries no reset; only written words are ever read back
  always_ff @(posedge CLK) begin
    if (wr_fire) mem[wr_ptr_reg[AW-1:0]] <= din;  // [RULE13]
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) in_reg <= '0;
    else if (wr_fire) in_reg <= din;  // [RULE14]
  end

  // output register: zero from reset, loads on array or register reads, else holds
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) dout_reg <= '0;  // [RULE7]
    else if (rd_fire) dout_reg <= mem[rd_ptr_reg[AW-1:0]];  // [RULE18]
    else if (rp_fire) dout_reg <= prog_rd_val;  // [RULE24]
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) wrote_any_reg <= 1'b0;
    else if (wr_fire || wp_fire || rp_fire) wrote_any_reg <= 1'b1;
  end

  always_comb begin
    flags_next[4] = !(cnt == CNT_FULL);
    flags_next[3] = !(cnt >= CNT_FULL - CW'(af_off_reg));
    flags_next[2] = !(cnt > CNT_HALF);
    flags_next[1] = !(cnt <= CW'(ae_off_reg));
    flags_next[0] = !(cnt == '0);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) flags_reg <= dcf_pkg::FLAGS_RST;  // [RULE4]
    else if (!run) flags_reg <= dcf_pkg::FLAGS_RST;  // [RULE4]
    else flags_reg <= flags_next;
  end

  assign FULL_FLAG_N         = flags_reg[4];
  assign ALMOST_FULL_FLAG_N  = flags_reg[3];
  assign HALF_FULL_FLAG_N    = flags_reg[2];
  assign ALMOST_EMPTY_FLAG_N = flags_reg[1];
  assign EMPTY_FLAG_N        = flags_reg[0];
  assign DATA_OUT_BUS        = dout_reg;
  // enable follows the pin after sampling, not the read logic [RULE21]
  assign DATA_OUT_BUS_OE     = !oe_n;

  // wishbone slave: ack one cycle after request, unmapped reads return zero
  assign bus_wr = WB_CYC_I && WB_STB_I && WB_WE_I && ack_reg;

  always_comb begin
    case (WB_ADR_I)
      dcf_pkg::ADR_AE_OFF: bus_rdata = 32'(ae_off_reg);
      dcf_pkg::ADR_AF_OFF: bus_rdata = 32'(af_off_reg);
      dcf_pkg::ADR_CTRL:   bus_rdata = 32'(ctrl_reg);
      dcf_pkg::ADR_STATUS: bus_rdata = 32'({run, enh_reg, flags_reg});
      dcf_pkg::ADR_COUNT:  bus_rdata = 32'(cnt);
      default:             bus_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) ack_reg <= 1'b0;
    else ack_reg <= WB_CYC_I && WB_STB_I && !ack_reg;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) WB_DAT_O <= 32'h0000_0000;
    else if (WB_CYC_I && WB_STB_I && !ack_reg) WB_DAT_O <= bus_rdata;
  end

  assign WB_ACK_O = ack_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  property p_init_empty;
    !run |-> (wr_ptr_reg == '0 && rd_ptr_reg == '0 && flags_reg == dcf_pkg::FLAGS_RST);
  endproperty
  a_init_empty: assert property (p_init_empty) else $error("not empty while starting up");  // [RULE4]

  property p_off_default;
    !run |-> (ae_off_reg == OFF_RST && af_off_reg == OFF_RST);
  endproperty
  a_off_default: assert property (p_off_default) else $error("offset defaults wrong");  // [RULE5]

  property p_enh_ctrl;
    (init_reg == dcf_pkg::INIT_LATCH && !pins.lvl[dcf_pkg::PIN_STRAP]) |=> (ctrl_reg[5:0] == 6'h3F && enh_reg);
  endproperty
  a_enh_ctrl: assert property (p_enh_ctrl) else $error("enhanced defaults not set");  // [RULE8]

  property p_std_ctrl;
    (init_reg == dcf_pkg::INIT_LATCH && pins.lvl[dcf_pkg::PIN_STRAP]) |=> (ctrl_reg == '0 && !enh_reg);
  endproperty
  a_std_ctrl: assert property (p_std_ctrl) else $error("standard defaults not set");  // [RULE6]

  property p_dout_zero;
    !wrote_any_reg |-> DATA_OUT_BUS == '0;
  endproperty
  a_dout_zero: assert property (p_dout_zero) else $error("output nonzero before first write");  // [RULE7]

  property p_wr_adv;
    wr_fire |=> (wr_ptr_reg == $past(wr_ptr_reg) + CW'(1)) && mem[$past(wr_ptr_reg[AW-1:0])] == $past(din);
  endproperty
  a_wr_adv: assert property (p_wr_adv) else $error("write did not store and advance");  // [RULE13]

  property p_wr_hold;
    (w_rise && wen_n) |=> $stable(wr_ptr_reg) && $stable(in_reg);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write with enable off");  // [RULE14]

  property p_full_block;
    !FULL_FLAG_N |-> !wr_fire;
  endproperty
  a_full_block: assert property (p_full_block) else $error("write while full");  // [RULE15]

  property p_empty_block;
    !EMPTY_FLAG_N |-> !rd_fire;
  endproperty
  a_empty_block: assert property (p_empty_block) else $error("read while empty");  // [RULE19]

  property p_wr_enable_second;
    (enh_reg && !wr_enable_second) |-> !(wr_fire || wp_fire);
  endproperty
  a_wr_enable_second: assert property (p_wr_enable_second) else $error("write without second enable");  // [RULE16]

  property p_rd_enable_second;
    (enh_reg && !rd_enable_second) |-> !rd_fire;
  endproperty
  a_rd_enable_second: assert property (p_rd_enable_second) else $error("read without second enable");  // [RULE20]

  property p_oe_inhibit;
    (enh_reg && ctrl_reg[dcf_pkg::CTRL_OE_RD_BIT] && !DATA_OUT_BUS_OE) |=> $stable(rd_ptr_reg);
  endproperty
  a_oe_inhibit: assert property (p_oe_inhibit) else $error("read advanced with outputs off");  // [RULE22]

  property p_rd_load;
    rd_fire |=> DATA_OUT_BUS == $past(mem[rd_ptr_reg[AW-1:0]]);
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("output not loaded from array");  // [RULE18]

  property p_wseq_std;
    (wp_fire && !psel_release && !enh_reg && wstep_reg == dcf_pkg::PS_AF) |=> wstep_reg == dcf_pkg::PS_AE;
  endproperty
  a_wseq_std: assert property (p_wseq_std) else $error("control word reachable in standard mode");  // [RULE23]

  property p_rseq_enh;
    (rp_fire && !psel_release && enh_reg && rstep_reg == dcf_pkg::PS_AF) |=> rstep_reg == dcf_pkg::PS_CTRL ##0 DATA_OUT_BUS == dcf_pkg::DATA_W'(af_off_reg);
  endproperty
  a_rseq_enh: assert property (p_rseq_enh) else $error("register read order wrong");  // [RULE24]

  c_full:     cover property (!FULL_FLAG_N);
  c_drain:    cover property (rd_fire ##1 !EMPTY_FLAG_N [*2]);
  c_ctrl_wr:  cover property (wp_fire && wstep_reg == dcf_pkg::PS_CTRL);
  c_oe_block: cover property (r_rise && !ren_n && !rd_fire && enh_reg && oe_n && psel_n);
endmodule : dcf_port_control

// *** dcf_port_host.sv ***
`timescale 1ns/1ps
// one host port strobe: a single 160 ns clock frame per request, low between frames
module dcf_port_host (
  input  wire logic CLK,
  input  wire logic RESETN,
  input  wire logic GO,
  output logic      PCLK,
  output logic      BUSY
);
  logic [3:0] cnt_reg;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_reg <= 4'h0;
    end else if (GO && cnt_reg == 4'h0) begin
      cnt_reg <= 4'h8;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  // delayed a fixed 7 ns off the system edge so port clock edges do not coincide with it
  assign #7 PCLK = (cnt_reg > 4'h4);
  assign BUSY = (cnt_reg != 4'h0);
endmodule : dcf_port_host

// *** dcf_port_control_tb.sv ***
`timescale 1ns/1ps
module dcf_port_control_tb;
  localparam int D = 16;
  localparam logic [31:0] OFF = 32'(D / 8 - 1);
  typedef struct packed { logic [7:0] a; logic [31:0] e; } dcf_row_s;
  logic        clk = 1'b0, resetn = 1'b0, wen_n = 1'b0, ren_n = 1'b0, psel_n = 1'b1;
  logic        wr_enable_second = 1'b1, rd_enable_second = 1'b1, oe_n = 1'b0, strap_n = 1'b1, go_w = 1'b0, go_r = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, oe, ff, aff, hf, aef, ef, ack, wclk, rclk, bw, br;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, q, wdo;
  logic [17:0] din = 18'h0, dout;
  int          err_total = 0, comparisons = 0;
  dcf_row_s    rows [6];

  always #10 clk = ~clk;

  dcf_port_host u_wr (.CLK(clk), .RESETN(resetn), .GO(go_w), .PCLK(wclk), .BUSY(bw));
  dcf_port_host u_rd (.CLK(clk), .RESETN(resetn), .GO(go_r), .PCLK(rclk), .BUSY(br));

  dcf_port_control #(.DEPTH(D)) u_dut (
    .CLK(clk), .RESETN(resetn), .WCLK(wclk), .RCLK(rclk), .WR_ENABLE_N(wen_n), .RD_ENABLE_N(ren_n),
    .PROGRAM_SELECT_N(psel_n), .WR_EXPAND_OR_ENABLE2(wr_enable_second), .RD_EXPAND_OR_ENABLE2(rd_enable_second),
    .OUT_ENABLE_N(oe_n), .ENHANCED_STRAP_N(strap_n), .DATA_IN_BUS(din), .DATA_OUT_BUS(dout),
    .DATA_OUT_BUS_OE(oe), .FULL_FLAG_N(ff), .ALMOST_FULL_FLAG_N(aff), .HALF_FULL_FLAG_N(hf),
    .ALMOST_EMPTY_FLAG_N(aef), .EMPTY_FLAG_N(ef), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(wdo), .WB_ACK_O(ack));

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // entered just after a rising edge; ack is a flop so it is sampled cleanly here
  // no local limit: only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    chk("ack", {31'h0, ack}, 32'h0);
  endtask : wb

  // one port frame, then margin for the two-flop sync and the flag lag
  task automatic pulse(input logic r);
    int n;
    n = 0;
    go_r <= r;
    go_w <= !r;
    @(posedge clk);
    go_r <= 1'b0;
    go_w <= 1'b0;
    @(posedge clk);
    while ((bw | br) && n < 40) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic rst(input logic s);
    resetn <= 1'b0;
    strap_n <= s;
    @(posedge clk);
    chk("flags", {27'h0, ff, aff, hf, aef, ef}, 32'h1C);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : rst

  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  initial begin
    rows = '{'{dcf_pkg::ADR_AE_OFF, OFF}, '{dcf_pkg::ADR_AF_OFF, OFF}, '{dcf_pkg::ADR_CTRL, 32'h0},
             '{dcf_pkg::ADR_STATUS, 32'h5C}, '{dcf_pkg::ADR_COUNT, 32'h0}, '{8'h14, 32'h0}};
    @(posedge clk);
    rst(1'b1);
    chk("dout", {14'h0, dout}, 32'h0);
    foreach (rows[i]) begin
      wb(1'b0, rows[i].a, 32'h0);
      chk("reg", q, rows[i].e);
    end
    wb(1'b1, dcf_pkg::ADR_AF_OFF, 32'h5);
    wb(1'b1, dcf_pkg::ADR_STATUS, 32'hFFFF);
    wb(1'b0, dcf_pkg::ADR_STATUS, 32'h0);
    chk("status", q, 32'h5C);
    $display("test reset and registers done");
    wen_n <= 1'b1;
    pulse(1'b0);
    wb(1'b0, dcf_pkg::ADR_COUNT, 32'h0);
    chk("count", q, 32'h0);
    wen_n <= 1'b0;
    for (int i = 0; i <= D; i++) begin
      din <= 18'(32'h100 + i);
      pulse(1'b0);
    end
    wb(1'b0, dcf_pkg::ADR_COUNT, 32'h0);
    chk("count", q, 32'(D));
    chk("full", {31'h0, ff}, 32'h0);
    chk("flags", {27'h0, ff, aff, hf, aef, ef}, 32'h03);
    oe_n <= 1'b1;
    pulse(1'b1);
    chk("oe", {31'h0, oe}, 32'h0);
    chk("data", {14'h0, dout}, 32'h100);
    oe_n <= 1'b0;
    for (int i = 1; i < D; i++) begin
      pulse(1'b1);
      chk("data", {14'h0, dout}, 32'h100 + i);
    end
    chk("empty", {31'h0, ef}, 32'h0);
    chk("oe", {31'h0, oe}, 32'h1);
    pulse(1'b1);
    chk("data", {14'h0, dout}, 32'h100 + D - 1);
    ren_n <= 1'b1;
    pulse(1'b0);
    pulse(1'b1);
    chk("hold", {14'h0, dout}, 32'h100 + D - 1);
    ren_n <= 1'b0;
    $display("test array traffic done");
    psel_n <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      pulse(1'b1);
      chk("preg", {14'h0, dout}, (i == 1) ? 32'h5 : OFF);
    end
    for (int i = 0; i < 3; i++) begin
      din <= 18'(3 - (i == 0 ? 0 : (i == 1 ? -1 : 1)));
      pulse(1'b0);
    end
    wb(1'b0, dcf_pkg::ADR_AE_OFF, 32'h0);
    chk("ae", q, 32'h2);
    wb(1'b0, dcf_pkg::ADR_AF_OFF, 32'h0);
    chk("af", q, 32'h4);
    psel_n <= 1'b1;
    $display("test pin programming done");
    rst(1'b0);
    wb(1'b0, dcf_pkg::ADR_CTRL, 32'h0);
    chk("ctrl", q, 32'h3F);
    wr_enable_second <= 1'b0;
    din <= 18'h2AB;
    pulse(1'b0);
    wr_enable_second <= 1'b1;
    wb(1'b0, dcf_pkg::ADR_COUNT, 32'h0);
    chk("count", q, 32'h0);
    pulse(1'b0);
    oe_n <= 1'b1;
    pulse(1'b1);
    wb(1'b0, dcf_pkg::ADR_COUNT, 32'h0);
    chk("count", q, 32'h1);
    oe_n <= 1'b0;
    rd_enable_second <= 1'b0;
    pulse(1'b1);
    wb(1'b0, dcf_pkg::ADR_COUNT, 32'h0);
    chk("count", q, 32'h1);
    rd_enable_second <= 1'b1;
    pulse(1'b1);
    wb(1'b0, dcf_pkg::ADR_COUNT, 32'h0);
    chk("count", q, 32'h0);
    chk("data", {14'h0, dout}, 32'h2AB);
    psel_n <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      pulse(1'b1);
      chk("ereg", {14'h0, dout}, (i == 2) ? 32'h3F : OFF);
    end
    for (int i = 0; i < 3; i++) begin
      din <= (i == 2) ? 18'h21 : 18'(i + 2);
      pulse(1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      wb(1'b0, (i == 0) ? dcf_pkg::ADR_AE_OFF : ((i == 1) ? dcf_pkg::ADR_AF_OFF : dcf_pkg::ADR_CTRL), 32'h0);
      chk("ewreg", q, (i == 2) ? 32'h21 : 32'(i + 2));
    end
    psel_n <= 1'b1;
    $display("test enhanced mode done");
    close_out();
  end

  // about 54 port frames of 8 cycles plus bus traffic stay well below this
  initial begin
    #200000;
    err_total++;
    close_out();
  end
endmodule : dcf_port_control_tb
